// ==== tsb_regs.svh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef TSB_REGS_SVH
`define TSB_REGS_SVH
// ****************************************************************
// Register word offsets (byte addresses).
// ****************************************************************
`define TSB_OFF_CST 8'h00
`define TSB_OFF_BTE 8'h04
`define TSB_OFF_STAT 8'h08
// ****************************************************************
// Control/status fields.
// ****************************************************************
`define TSB_CST_ITM_LO 0
`define TSB_CST_ITM_HI 1
`define TSB_CST_SWT 2
`define TSB_CST_SSTEP 3
`define TSB_CST_MASK 16'h000F
`define TSB_CST_RST 16'h0000
`define TSB_BTE_RST 16'h0000
// ****************************************************************
// Command decode.
// ****************************************************************
`define TSB_CMD_WHI 4'h1
`define TSB_CMD_WLO 4'h2
`define TSB_CMD_CTRL 4'h3
`define TSB_CMD_BCAST 4'h4
`define TSB_CTRL_SWTRIG 4'hF
`define TSB_STEP_DLY_DEF 16'h0004
`endif

// ==== tsb_pkg.sv ====
// Types shared by the broadcast sequencer files.
package tsb_pkg;
  typedef enum logic [2:0] {
    TSB_IDLE = 3'h1,
    TSB_WAIT = 3'h2,
    TSB_DLY = 3'h4
  } tsb_state_t;
endpackage : tsb_pkg

// ==== tsb_cmd_if.sv ====
// Command strobe and enables from the sequencer core to its broadcast fan-out.
`timescale 1ns/10ps
interface tsb_cmd_if;
  logic fire;
  logic [15:0] enables;
  modport core (output fire, output enables);
  modport fan (input fire, input enables);
endinterface : tsb_cmd_if

// ==== tsb_fanout.sv ====
// Broadcast fan-out: turns one broadcast strobe into enabled trigger pulses.
`timescale 1ns/10ps
module tsb_fanout (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Command side.
  tsb_cmd_if.fan cmd,
  // Trigger outputs.
  output logic [15:0] trig_out
);
  logic [15:0] trig_r;
  logic [15:0] trig_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_bit
      always_comb begin
        trig_nxt[gi] = cmd.fire & cmd.enables[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_r <= 16'h0000;
    end else begin
      trig_r <= trig_nxt;
    end
  end

  assign trig_out = trig_r;

  property p_bcast_pulse;
    @(posedge clk) disable iff (!rst_n)
      cmd.fire |=> (trig_out == $past(cmd.enables));
  endproperty
  a_bcast_pulse: assert property (p_bcast_pulse)
    else $error("Broadcast pulses do not match enables.");

  property p_no_pulse;
    @(posedge clk) disable iff (!rst_n)
      !cmd.fire |=> (trig_out == 16'h0000);
  endproperty
  a_no_pulse: assert property (p_no_pulse)
    else $error("Trigger pulse without broadcast.");
endmodule : tsb_fanout

// ==== tsb_top.sv ====
// Trigger sequencer wait-mode control and broadcast map with Wishbone slave.
`timescale 1ns/10ps
`include "tsb_regs.svh"
module tsb_top #(
  parameter logic [15:0] STEP_DELAY = `TSB_STEP_DLY_DEF
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RSTN,
  // Wishbone slave.
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Sequencer command from the decoder.
  input wire logic CMD_VALID,
  input wire logic [3:0] CMD_OP,
  input wire logic [3:0] CMD_OPTION,
  output logic CMD_READY,
  // Trigger input pin.
  input wire logic TRIG_IN,
  // Broadcast trigger outputs.
  output logic [15:0] BCAST_OUT
);
  logic [15:0] cst_r, cst_nxt, bte_r, bte_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [2:0] sync_r;
  logic lvl_r, lvl_nxt, tgt_r, tgt_nxt, hit, wr;
  logic [15:0] cnt_r, cnt_nxt;
  tsb_pkg::tsb_state_t st_r, st_nxt;
  tsb_cmd_if cmd_if ();

  // ****************************************************************
  // Register slave.
  // ****************************************************************
  // Registers answer one cycle after the request; ack drops next cycle.
  assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~ack_r;
  always_comb begin
    cst_nxt = cst_r;
    bte_nxt = bte_r;
    ack_nxt = WB_CYC_I & WB_STB_I & ~ack_r;
    dat_nxt = 32'h0000_0000;
    if (wr && WB_ADR_I == `TSB_OFF_CST) begin
      if (WB_SEL_I[0]) begin
        cst_nxt = {8'h00, WB_DAT_I[7:0]} & `TSB_CST_MASK;
      end
    end
    if (wr && WB_ADR_I == `TSB_OFF_BTE) begin
      if (WB_SEL_I[0]) begin
        bte_nxt[7:0] = WB_DAT_I[7:0];
      end
      if (WB_SEL_I[1]) begin
        bte_nxt[15:8] = WB_DAT_I[15:8];
      end
    end
    unique case (WB_ADR_I)
      `TSB_OFF_CST: dat_nxt = {16'h0000, cst_r};
      `TSB_OFF_BTE: dat_nxt = {16'h0000, bte_r};
      `TSB_OFF_STAT: dat_nxt = {29'h0, st_r};
      default: dat_nxt = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Pin synchroniser and wait-for-input engine.
  // ****************************************************************
  // Level detect catches a level already present; edge detect needs a
  // transition, so a line parked at the target level never fires.
  always_comb begin
    lvl_nxt = (sync_r[2] == sync_r[1]) ? sync_r[1] : lvl_r;
    if (cst_r[`TSB_CST_ITM_HI]) begin
      hit = (lvl_r == tgt_r);
    end else begin
      hit = (lvl_r == tgt_r) && (lvl_nxt != lvl_r) ? 1'b0 :
            (lvl_nxt == tgt_r) && (lvl_nxt != lvl_r);
    end
  end

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    tgt_nxt = tgt_r;
    CMD_READY = 1'b0;
    cmd_if.fire = 1'b0;
    cmd_if.enables = bte_r;
    unique case (st_r)
      tsb_pkg::TSB_IDLE: begin
        CMD_READY = 1'b1;
        if (CMD_VALID) begin
          // Only the two wait commands look at the wait mode.
          if (CMD_OP == `TSB_CMD_WHI || CMD_OP == `TSB_CMD_WLO) begin
            st_nxt = tsb_pkg::TSB_WAIT;
            tgt_nxt = (CMD_OP == `TSB_CMD_WHI);
          end else if (CMD_OP == `TSB_CMD_BCAST) begin
            cmd_if.fire = 1'b1;
          end else if (CMD_OP == `TSB_CMD_CTRL &&
                       CMD_OPTION == `TSB_CTRL_SWTRIG) begin
            cmd_if.fire = cst_r[`TSB_CST_SWT];
          end
        end
      end
      tsb_pkg::TSB_WAIT: begin
        if (hit) begin
          if (!cst_r[`TSB_CST_ITM_LO]) begin
            st_nxt = tsb_pkg::TSB_DLY;
            cnt_nxt = STEP_DELAY;
          end else begin
            st_nxt = tsb_pkg::TSB_IDLE;
          end
        end
      end
      tsb_pkg::TSB_DLY: begin
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r <= 16'h0001) begin
          st_nxt = tsb_pkg::TSB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cst_r <= `TSB_CST_RST;
      bte_r <= `TSB_BTE_RST;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      sync_r <= 3'h0;
      lvl_r <= 1'b0;
      tgt_r <= 1'b0;
      cnt_r <= 16'h0000;
      st_r <= tsb_pkg::TSB_IDLE;
    end else begin
      cst_r <= cst_nxt;
      bte_r <= bte_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      sync_r <= {sync_r[1:0], TRIG_IN};
      lvl_r <= lvl_nxt;
      tgt_r <= tgt_nxt;
      cnt_r <= cnt_nxt;
      st_r <= st_nxt;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;

  tsb_fanout u_fan (
    .clk(CLK),
    .rst_n(RSTN),
    .cmd(cmd_if.fan),
    .trig_out(BCAST_OUT)
  );

  property p_skip_delay;
    @(posedge CLK) disable iff (!RSTN)
      (st_r == tsb_pkg::TSB_WAIT && hit && cst_r[`TSB_CST_ITM_LO])
        |=> (st_r == tsb_pkg::TSB_IDLE);
  endproperty
  a_skip_delay: assert property (p_skip_delay)
    else $error("Step delay not skipped.");

  property p_run_delay;
    @(posedge CLK) disable iff (!RSTN)
      (st_r == tsb_pkg::TSB_WAIT && hit && !cst_r[`TSB_CST_ITM_LO])
        |=> (st_r == tsb_pkg::TSB_DLY) && (cnt_r == STEP_DELAY);
  endproperty
  a_run_delay: assert property (p_run_delay)
    else $error("Step delay not started.");

  property p_other_cmd;
    @(posedge CLK) disable iff (!RSTN)
      (st_r == tsb_pkg::TSB_IDLE && CMD_VALID && CMD_OP != `TSB_CMD_WHI &&
       CMD_OP != `TSB_CMD_WLO) |=> (st_r == tsb_pkg::TSB_IDLE);
  endproperty
  a_other_cmd: assert property (p_other_cmd)
    else $error("Non-wait command entered wait.");

  property p_level;
    @(posedge CLK) disable iff (!RSTN)
      (st_r == tsb_pkg::TSB_WAIT && cst_r[`TSB_CST_ITM_HI] &&
       lvl_r == tgt_r) |=> (st_r != tsb_pkg::TSB_WAIT);
  endproperty
  a_level: assert property (p_level)
    else $error("Level detect missed.");

  property p_swtrig;
    @(posedge CLK) disable iff (!RSTN)
      (st_r == tsb_pkg::TSB_IDLE && CMD_VALID && CMD_OP == `TSB_CMD_CTRL &&
       !cst_r[`TSB_CST_SWT]) |=> (BCAST_OUT == 16'h0000);
  endproperty
  a_swtrig: assert property (p_swtrig)
    else $error("Software trigger fired while disabled.");

  property p_ack;
    @(posedge CLK) disable iff (!RSTN)
      (WB_CYC_I && WB_STB_I && !ack_r) |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack)
    else $error("Bus ack timing wrong.");

  property p_bcast_map;
    @(posedge CLK) disable iff (!RSTN)
      (st_r == tsb_pkg::TSB_IDLE && CMD_VALID && CMD_OP == `TSB_CMD_BCAST)
        |=> (BCAST_OUT == $past(bte_r));
  endproperty
  a_bcast_map: assert property (p_bcast_map)
    else $error("Broadcast map does not follow enables.");
endmodule : tsb_top

// ==== tsb_periph_model.sv ====
// Peripheral-side model that counts the broadcast trigger pulses it sees.
`timescale 1ns/10ps
module tsb_periph_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Broadcast triggers from the sequencer.
  input wire logic [15:0] trig,
  // Observations for the bench.
  output logic [15:0] n_pulse,
  output logic stuck
);
  logic [15:0] prev_r;
  // Each trigger must be one pulse; a level held two cycles would double
  // clock a compare channel, so it is flagged.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_pulse <= 16'h0000;
      stuck <= 1'h0;
      prev_r <= 16'h0000;
    end else begin
      n_pulse <= n_pulse + 16'($countones(trig));
      stuck <= stuck | (|(trig & prev_r));
      prev_r <= trig;
    end
  end
endmodule : tsb_periph_model

// ==== tsb_top_test.sv ====
// Self-checking bench for the wait modes and the broadcast map.
`timescale 1ns/10ps
`include "tsb_regs.svh"
module tsb_top_test;
  localparam logic [15:0] SD = 16'h0006;
  logic clk = 1'h0, rstn = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic cv = 1'h0, tin = 1'h0, ack, crdy, stuck;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, cop = 4'h0, copt = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [15:0] bout, np, en, seed = 16'h8D44, exp_p = 16'h0000;
  int n_mismatch = 0, n_tests = 0, cyc_n = 0, t, tw[4];
  always #50 clk = ~clk;
  tsb_top #(.STEP_DELAY(SD)) dut (.CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CMD_VALID(cv),
    .CMD_OP(cop), .CMD_OPTION(copt), .CMD_READY(crdy), .TRIG_IN(tin),
    .BCAST_OUT(bout));
  tsb_periph_model pm (.clk(clk), .rst_n(rstn), .trig(bout), .n_pulse(np),
    .stuck(stuck));
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Request stands until the edge at which ack is seen; only the timeout
  // ends a wait for an answer that never comes.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, 4'h3};
    do begin
      @(posedge clk);
    end while (ack !== 1'h1);
    q = rdat;
    {cyc, stb, we} <= 3'h0;
  endtask : wb
  task automatic cmd(input logic [3:0] op, input logic [3:0] opt);
    @(posedge clk);
    {cv, cop, copt} <= {1'h1, op, opt};
    do begin
      @(posedge clk);
    end while (crdy !== 1'h1);
    cv <= 1'h0;
  endtask : cmd
  task wrap_up;
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n > 3000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    wb(1'h0, `TSB_OFF_BTE, 32'h0);
    chk(q, {16'h0000, `TSB_BTE_RST});
    wb(1'h1, 8'h0C, 32'hFFFFFFFF);
    wb(1'h0, 8'h0C, 32'h0);
    chk(q, 32'h0);
    // Mode 10 is left set so broadcasts show they ignore the wait mode.
    wb(1'h1, `TSB_OFF_CST, 32'h2);
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      en = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed;
      wb(1'h1, `TSB_OFF_BTE, {16'h0000, en});
      wb(1'h0, `TSB_OFF_BTE, 32'h0);
      chk(q, {16'h0000, en});
      cmd(`TSB_CMD_BCAST, seed[3:0]);
      @(negedge clk);
      chk(bout, en);
      chk(crdy, 1'h1);
      @(negedge clk);
      chk(bout, 16'h0000);
      exp_p += 16'($countones(en));
    end
    chk(np, exp_p);
    // A reset in mid-run must clear the registers and the pulse count.
    @(posedge clk);
    rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    exp_p = 16'h0000;
    wb(1'h0, `TSB_OFF_BTE, 32'h0);
    chk(q, {16'h0000, `TSB_BTE_RST});
    wb(1'h0, `TSB_OFF_STAT, 32'h0);
    chk(q, 32'h1);
    seed = lfsr(seed);
    en = seed;
    wb(1'h1, `TSB_OFF_BTE, {16'h0000, en});
    for (int s = 0; s < 4; s++) begin
      seed = lfsr(seed);
      wb(1'h1, `TSB_OFF_CST, {29'h0, s[0], 2'h0});
      cmd(`TSB_CMD_CTRL, s[1] ? `TSB_CTRL_SWTRIG : {1'h0, seed[2:0]});
      @(negedge clk);
      chk(bout, (s == 3) ? en : 16'h0000);
      exp_p += (s == 3) ? 16'($countones(en)) : 16'h0000;
    end
    for (int m = 0; m < 4; m++) begin
      wb(1'h1, `TSB_OFF_CST, 32'(m));
      wb(1'h0, `TSB_OFF_CST, 32'h0);
      chk(q, 32'(m));
      tin <= ~m[1];
      repeat (5) @(posedge clk);
      cmd(m[1] ? `TSB_CMD_WLO : `TSB_CMD_WHI, seed[3:0]);
      if (!m[1]) begin
        // Edge mode must not fire on a level that was already there.
        repeat (12) @(negedge clk);
        chk(crdy, 1'h0);
        @(posedge clk);
        tin <= 1'h0;
        repeat (5) @(posedge clk);
        tin <= 1'h1;
      end
      t = 0;
      do begin
        @(negedge clk);
        t++;
      end while (crdy !== 1'h1 && t < 60);
      tw[m] = t;
    end
    chk(32'(tw[2] - tw[3]), SD);
    chk(32'(tw[0] - tw[1]), SD);
    chk(np, exp_p);
    chk(stuck, 1'h0);
    wrap_up;
  end
endmodule : tsb_top_test
